// file: src/btfp_frame_packer.sv
// btfp_frame_packer: builds the 256-bit buoy telemetry message and rotates six layouts.
// assumes sensor bundles and tx_start_in are on ref_clk_in; the pair strap is a pin.
`timescale 1ns/100ps
module btfp_frame_packer #(
  parameter int unsigned TICK_CYCLES = btfp_pkg::TICK_CYCLES,
  parameter int unsigned SEQ_MS      = btfp_pkg::SEQ_PERIOD_MS,
  parameter int unsigned OFFSET_MS   = btfp_pkg::PAIR_OFFSET_MS
) (
  input  wire logic                btfp_unused_never_in_dummy_guard_in,
  input  wire logic                ref_clk_in,
  input  wire logic                resetn_in,
  input  wire logic                second_pair_in,
  input  wire btfp_pkg::btfp_met_s met_in,
  input  wire btfp_pkg::btfp_ice_s ice_in,
  input  wire btfp_pkg::btfp_fast_s fast_in,
  input  wire btfp_pkg::btfp_slow_s slow_in,
  input  wire logic                tx_start_in,
  output logic [255:0]             msg_out,
  output logic [2:0]               sequence_id_out,
  output logic                     msg_new_out,
  output logic                     refresh_out,
  output logic                     slow_refresh_out,
  output logic                     tx_bit_out,
  output logic                     tx_bit_valid_out
);

  // ************************************************************
  // derived constants and checks
  // ************************************************************
  localparam int unsigned TICK_W  = $clog2(TICK_CYCLES + 1);
  // two spare counts for ticks caught while a message is being built
  localparam int unsigned MS_W    = $clog2(SEQ_MS + 2);
  localparam int unsigned OFF_SEQ = (OFFSET_MS / SEQ_MS) % btfp_pkg::SEQ_COUNT;
  localparam logic [2:0]  OFF_SID = 3'(OFF_SEQ + 1);
  localparam logic [MS_W-1:0] OFF_MS = MS_W'(OFFSET_MS % SEQ_MS);

  generate
    if (TICK_CYCLES < 1 || SEQ_MS < 3) begin : g_bad_timing
      $error("tick divider and sequence period must be at least 1 and 3");
    end
  endgenerate

  // ************************************************************
  // strap capture and tick divider
  // ************************************************************
  btfp_pkg::btfp_phase_e phase;
  logic [2:0]            strap_s;
  logic [1:0]            strap_cnt;
  logic                  second_pair;
  logic [TICK_W-1:0]     tick_cnt;
  logic                  tick;
  logic [MS_W-1:0]       ms_cnt;
  logic [2:0]            seq_cur;
  logic                  first_load;
  logic                  fast_load;
  logic                  slow_load;
  logic                  have_msg;
  logic [255:0]          tx_shift;
  logic [7:0]            tx_cnt;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strap_s <= 3'h0;
    end else begin
      strap_s <= {strap_s[1:0], second_pair_in};
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (phase == btfp_pkg::PH_STRAP) begin
      // restart so schedule ticks fall whole ticks after the start edge
      tick_cnt <= TICK_W'(1 % TICK_CYCLES);
      tick     <= (TICK_CYCLES == 1);
    end else if (tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  // ************************************************************
  // sequence scheduler
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase       <= btfp_pkg::PH_STRAP;
      strap_cnt   <= 2'h0;
      second_pair <= 1'b0;
      ms_cnt      <= '0;
      seq_cur     <= btfp_pkg::SID_FIRST;
      first_load  <= 1'b1;
    end else begin
      unique case (phase)
        btfp_pkg::PH_STRAP: begin
          // the strap counts once the second and third stages agree
          if (strap_cnt != 2'(btfp_pkg::STRAP_SETTLE)) begin
            strap_cnt <= strap_cnt + 1'b1;
          end else if (strap_s[1] == strap_s[2]) begin
            second_pair <= strap_s[2];
            seq_cur     <= strap_s[2] ? OFF_SID : btfp_pkg::SID_FIRST;
            ms_cnt      <= strap_s[2] ? OFF_MS : '0;
            phase       <= btfp_pkg::PH_LOAD;
          end
        end
        btfp_pkg::PH_LOAD: begin
          // ticks keep counting while the message is built
          if (tick) begin
            ms_cnt <= ms_cnt + 1'b1;
          end
          first_load <= 1'b0;
          phase      <= btfp_pkg::PH_PACK;
        end
        btfp_pkg::PH_PACK: begin
          if (tick) begin
            ms_cnt <= ms_cnt + 1'b1;
          end
          phase <= btfp_pkg::PH_RUN;
        end
        btfp_pkg::PH_RUN: begin
          if (tick) begin
            if (ms_cnt >= MS_W'(SEQ_MS - 1)) begin
              ms_cnt  <= '0;
              seq_cur <= (seq_cur == btfp_pkg::SID_LAST) ? btfp_pkg::SID_FIRST
                                                         : seq_cur + 3'h1;
              phase   <= btfp_pkg::PH_LOAD;
            end else begin
              ms_cnt <= ms_cnt + 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ************************************************************
  // field snapshots
  // ************************************************************
  btfp_pkg::btfp_met_s  met_q;
  btfp_pkg::btfp_ice_s  ice_q;
  btfp_pkg::btfp_fast_s fast_q;
  btfp_pkg::btfp_slow_s slow_q;
  localparam int unsigned LIVE_W = $bits(btfp_pkg::btfp_met_s) + $bits(btfp_pkg::btfp_ice_s)
                                 + $bits(btfp_pkg::btfp_fast_s);
  localparam int unsigned SLOW_W = $bits(btfp_pkg::btfp_slow_s);
  logic [LIVE_W-1:0] live_q;
  logic [SLOW_W-1:0] slow_v;

  // fast groups caught at every sequence start
  assign fast_load = (phase == btfp_pkg::PH_LOAD);
  // slow groups only when a cycle begins or on the first load after the strap
  assign slow_load = fast_load && (seq_cur == btfp_pkg::SID_FIRST || first_load);

  btfp_field_latch #(.W(LIVE_W)) u_live_latch (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .load_in    (fast_load),
    .d_in       ({met_in, ice_in, fast_in}),
    .q_out      (live_q)
  );

  btfp_field_latch #(.W(SLOW_W)) u_slow_latch (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .load_in    (slow_load),
    .d_in       (slow_in),
    .q_out      (slow_v)
  );

  assign {met_q, ice_q, fast_q} = live_q;
  assign slow_q = slow_v;

  // ************************************************************
  // layout
  // ************************************************************
  function automatic logic [70:0] met_head(input btfp_pkg::btfp_met_s m);
    // common met prefix of odd layouts
    met_head = {m.met_battery_voltage, m.met_day_number, m.met_time_code,
                m.compass_heading, m.tilt_x, m.tilt_y, m.air_pressure,
                m.wind_speed, m.wind_direction, m.air_temperature};
  endfunction

  function automatic logic [214:0] even_tail(input btfp_pkg::btfp_fast_s f,
                                             input btfp_pkg::btfp_slow_s s);
    // profiler keeps its low 135 bits
    even_tail = {f.profiler_bytes[btfp_pkg::PROFILER_BITS-1:0], s.oxygen_ctd_bytes,
                 f.light_attenuation, f.pigment_glow};
  endfunction

  function automatic logic [255:0] pack_msg(input logic [2:0] sequence_id,
                                            input btfp_pkg::btfp_met_s m,
                                            input btfp_pkg::btfp_ice_s i,
                                            input btfp_pkg::btfp_fast_s f,
                                            input btfp_pkg::btfp_slow_s s);
    // fixed 256 bits, no timestamp or checksum appended
    // concatenation puts each msb at the lowest bit number
    case (sequence_id)
      3'h1: begin
        // first third of the thermistor block
        pack_msg = {sequence_id, met_head(m), m.mooring_tension[23 -: btfp_pkg::TEN_SEQ1_BITS],
                    i.ice_battery_voltage, i.ice_day_number, i.ice_time_code,
                    i.ice_stress, s.ice_thermistors[32:22]};
      end
      3'h2: begin
        // zero pads at bits 4 and 41
        pack_msg = {sequence_id, 1'b0, s.collector_condition, f.shallow_ctd_bytes, 1'b0,
                    even_tail(f, s)};
      end
      3'h3: begin
        pack_msg = {sequence_id, met_head(m), m.mooring_tension[23 -: btfp_pkg::TEN_SEQ3_BITS],
                    i.echo_depth, i.ice_stress, s.ice_thermistors[21:11]};
      end
      3'h4: begin
        pack_msg = {sequence_id, s.water_filter_status, s.deep_ctd_bytes, 1'b0, even_tail(f, s)};
      end
      3'h5: begin
        pack_msg = {sequence_id, met_head(m), m.mooring_tension, f.transmitter_battery_voltage,
                    f.logger_battery_voltage, i.ice_stress, s.ice_thermistors[10:0]};
      end
      3'h6: begin
        // current meter keeps its low 38 bits
        pack_msg = {sequence_id, s.current_meter_bytes[btfp_pkg::CURRENT_BITS-1:0],
                    even_tail(f, s)};
      end
      default: begin
        pack_msg = {sequence_id, 253'h0};
      end
    endcase
  endfunction

  // ************************************************************
  // message register
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      msg_out          <= 256'h0;
      sequence_id_out  <= 3'h0;
      msg_new_out      <= 1'b0;
      refresh_out      <= 1'b0;
      slow_refresh_out <= 1'b0;
      have_msg         <= 1'b0;
    end else begin
      refresh_out      <= fast_load;
      slow_refresh_out <= slow_load;
      msg_new_out      <= (phase == btfp_pkg::PH_PACK);
      if (phase == btfp_pkg::PH_PACK) begin
        msg_out         <= pack_msg(seq_cur, met_q, ice_q, fast_q, slow_q);
        sequence_id_out <= seq_cur;
        have_msg        <= 1'b1;
      end
    end
  end

  // ************************************************************
  // serial hand-over
  // ************************************************************
  // a private copy keeps a burst intact when the message changes mid-way
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_shift         <= 256'h0;
      tx_cnt           <= 8'h0;
      tx_bit_out       <= 1'b0;
      tx_bit_valid_out <= 1'b0;
    end else if (!tx_bit_valid_out) begin
      if (tx_start_in && have_msg) begin
        tx_bit_out       <= msg_out[255];
        tx_shift         <= {msg_out[254:0], 1'b0};
        tx_cnt           <= 8'h0;
        tx_bit_valid_out <= 1'b1;
      end
    end else if (tx_cnt == 8'hff) begin
      tx_bit_valid_out <= 1'b0;
      tx_bit_out       <= 1'b0;
    end else begin
      tx_bit_out <= tx_shift[255];
      tx_shift   <= {tx_shift[254:0], 1'b0};
      tx_cnt     <= tx_cnt + 8'h1;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  logic [2:0]    prev_sid;
  logic [1:0]    msg_seen;
  logic [MS_W:0] ms_since;
  logic [255:0]  tx_ref;

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_sid <= 3'h0;
      msg_seen <= 2'h0;
      ms_since <= '0;
      tx_ref   <= 256'h0;
    end else begin
      if (msg_new_out) begin
        prev_sid <= sequence_id_out;
        msg_seen <= (msg_seen == 2'h3) ? msg_seen : msg_seen + 2'h1;
      end
      ms_since <= msg_new_out ? (MS_W+1)'(tick) : ms_since + (MS_W+1)'(tick);
      if (tx_start_in && have_msg && !tx_bit_valid_out) begin
        tx_ref <= msg_out;
      end
    end
  end

  sid_field_a: assert property (msg_new_out |->
    msg_out[btfp_pkg::IDX_SID -: 3] == sequence_id_out) else $error("sid field wrong");
  sid_range_a: assert property (msg_new_out |->
    sequence_id_out >= 3'h1 && sequence_id_out <= 3'h6) else $error("sid out of range");
  seq_step_a: assert property (msg_new_out && msg_seen != 2'h0 |->
    sequence_id_out == ((prev_sid == 3'h6) ? 3'h1 : prev_sid + 3'h1))
    else $error("sequence did not advance by one");
  hold_time_a: assert property (msg_new_out && msg_seen[1] |->
    ms_since == (MS_W+1)'(SEQ_MS)) else $error("sequence held for wrong time");
  pair_start_a: assert property (msg_new_out && msg_seen == 2'h0 |->
    sequence_id_out == (second_pair ? OFF_SID : 3'h1)) else $error("wrong first sequence");
  refresh_first_a: assert property (msg_new_out |->
    $past(fast_load, 2)) else $error("message not preceded by refresh");
  slow_once_a: assert property (slow_refresh_out && msg_seen != 2'h0 |=>
    msg_new_out && sequence_id_out == 3'h1) else $error("slow group reloaded mid cycle");
  seq2_pad_a: assert property (msg_new_out && sequence_id_out == 3'h2 |->
    !msg_out[btfp_pkg::IDX_SEQ2_PAD_A] && !msg_out[btfp_pkg::IDX_SEQ2_PAD_B])
    else $error("sequence 2 pad bits not zero");
  seq1_met_a: assert property (msg_new_out && sequence_id_out == 3'h1 |->
    msg_out[btfp_pkg::IDX_MET_BATT -: 3] == met_q.met_battery_voltage)
    else $error("met battery misplaced");
  therm_third_a: assert property (msg_new_out && sequence_id_out == 3'h3 |->
    msg_out[btfp_pkg::IDX_THERM -: 110] == slow_q.ice_thermistors[21:11])
    else $error("thermistor third misplaced");
  seq5_power_a: assert property (msg_new_out && sequence_id_out == 3'h5 |->
    msg_out[btfp_pkg::IDX_SEQ5_POWER -: 6] == {fast_q.transmitter_battery_voltage,
    fast_q.logger_battery_voltage}) else $error("pair battery misplaced");
  serial_order_a: assert property (tx_bit_valid_out |->
    tx_bit_out == tx_ref[8'hff - tx_cnt]) else $error("serial bit out of order");

  wrap_c: cover property (msg_new_out && prev_sid == 3'h6 && sequence_id_out == 3'h1);
  pair2_c: cover property (msg_new_out && second_pair);
  serial_end_c: cover property (tx_bit_valid_out && tx_cnt == 8'hff);
  seq2_c: cover property (msg_new_out && sequence_id_out == 3'h2);

endmodule

// file: inc/btfp_pkg.sv
// btfp_pkg: constants, field bundles and types of the buoy telemetry frame packer.
// assumes one 100 MHz clock; sensor bundles arrive on that same clock.
package btfp_pkg;

  // ************************************************************
  // message geometry
  // ************************************************************
  localparam int unsigned MSG_BITS       = 256;
  localparam int unsigned SEQ_COUNT      = 6;
  localparam logic [2:0]  SID_FIRST      = 3'h1;
  localparam logic [2:0]  SID_LAST       = 3'h6;
  localparam int unsigned TEN_SEQ1_BITS  = 16;
  localparam int unsigned TEN_SEQ3_BITS  = 18;
  localparam int unsigned PROFILER_BITS  = 135;
  localparam int unsigned CURRENT_BITS   = 38;
  localparam int unsigned THERM_PER_SEQ  = 11;

  // bit number n (1 = first sent) sits at vector index MSG_BITS - n
  localparam int unsigned IDX_SID        = MSG_BITS - 1;
  localparam int unsigned IDX_MET_BATT   = MSG_BITS - 4;
  localparam int unsigned IDX_SEQ2_PAD_A = MSG_BITS - 4;
  localparam int unsigned IDX_SEQ2_PAD_B = MSG_BITS - 41;
  localparam int unsigned IDX_SEQ5_POWER = MSG_BITS - 99;
  localparam int unsigned IDX_THERM      = MSG_BITS - 147;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned TICK_CYCLES    = CLK_HZ / 1_000_000 * TICK_US;
  // just under one hour per sequence: 59 min 50 s, counted in 1 ms ticks
  localparam int unsigned SEQ_PERIOD_MS  = 3_590_000;
  // second pair runs three and a half hours apart
  localparam int unsigned PAIR_OFFSET_MIN = 210;
  localparam int unsigned PAIR_OFFSET_MS = PAIR_OFFSET_MIN * 60 * 1000;
  localparam int unsigned STRAP_SETTLE   = 3;

  // ************************************************************
  // field bundles
  // ************************************************************
  typedef struct packed {
    logic [2:0]  met_battery_voltage;
    logic [1:0]  met_day_number;
    logic [7:0]  met_time_code;
    logic [7:0]  compass_heading;
    logic [6:0]  tilt_x;
    logic [6:0]  tilt_y;
    logic [9:0]  air_pressure;
    logic [7:0]  wind_speed;
    logic [7:0]  wind_direction;
    logic [9:0]  air_temperature;
    logic [23:0] mooring_tension;
  } btfp_met_s;

  typedef struct packed {
    logic [2:0]       ice_battery_voltage;
    logic [2:0]       ice_day_number;
    logic [7:0]       ice_time_code;
    logic [11:0]      echo_depth;
    logic [5:0][6:0]  ice_stress;      // [5] = stress_1_sigma_1
  } btfp_ice_s;

  typedef struct packed {
    logic [31:0]  shallow_ctd_bytes;
    logic [135:0] profiler_bytes;
    logic [11:0]  light_attenuation;
    logic [11:0]  pigment_glow;
    logic [2:0]   transmitter_battery_voltage;
    logic [2:0]   logger_battery_voltage;
  } btfp_fast_s;

  typedef struct packed {
    logic [3:0]        collector_condition;
    logic [4:0]        water_filter_status;
    logic [31:0]       deep_ctd_bytes;
    logic [55:0]       oxygen_ctd_bytes;
    logic [39:0]       current_meter_bytes;
    logic [32:0][9:0]  ice_thermistors;  // [32] = ice_thermistor_1
  } btfp_slow_s;

  typedef enum logic [1:0] {
    PH_STRAP,
    PH_LOAD,
    PH_PACK,
    PH_RUN
  } btfp_phase_e;

endpackage

// file: src/btfp_field_latch.sv
// btfp_field_latch: snapshot register for one group of sensor fields.
// assumes load_in is a one-cycle pulse on the same clock as the data.
`timescale 1ns/100ps
module btfp_field_latch #(
  parameter int unsigned W = 8
) (
  input  wire logic         ref_clk_in,
  input  wire logic         resetn_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  generate
    if (W < 1) begin : g_bad_width
      $error("field latch width must be at least one");
    end
  endgenerate

  // holds the group steady while the transmitter repeats the message
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q_out <= '0;
    end else if (load_in) begin
      q_out <= d_in;
    end
  end

endmodule

// file: dv/btfp_tx_model.sv
// btfp_tx_model: transmitter terminal that takes serial copies of the message.
// assumes the packer's serial port on the same clock; req_in comes from the bench.
`timescale 1ns/100ps
module btfp_tx_model (
  input  wire logic    ref_clk_in,
  input  wire logic    resetn_in,
  input  wire logic    req_in,
  input  wire logic    tx_bit_in,
  input  wire logic    tx_bit_valid_in,
  output logic         tx_start_out,
  output logic [255:0] word_out,
  output logic [2:0]   sid_out,
  output logic [9:0]   bits_out,
  output logic         done_out
);
  // ********************
  // receiver
  // ********************
  logic [9:0] cnt;
  assign tx_start_out = req_in;
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      word_out <= '0;
      cnt <= '0;
      bits_out <= '0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (tx_bit_valid_in) begin
        word_out <= {word_out[254:0], tx_bit_in};
        cnt <= cnt + 10'h1;
      end else if (cnt != 10'h0) begin
        // burst length is only known once valid drops
        bits_out <= cnt;
        done_out <= 1'b1;
        cnt <= '0;
      end
    end
  end
  assign sid_out = word_out[255:253];
endmodule

// file: dv/tb_btfp_frame_packer.sv
// tb_btfp_frame_packer: self-checking bench for the buoy telemetry frame packer.
// assumes shortened timing parameters; a second packer serves the offset pair.
`timescale 1ns/100ps
module tb_btfp_frame_packer;
  // ********************
  // setup
  // ********************
  localparam int unsigned TC  = 2;
  localparam int unsigned SM  = 10;
  localparam int unsigned OM  = 35;
  localparam int unsigned PER = TC * SM;
  logic                 ref_clk_in, resetn_in, req, tx_start, tx_bit, tx_valid, done;
  logic                 new1, new2, ref1, sref1, prev_ref, prev_sref;
  logic [2:0]           sequence_id, sid2, rsid, want, want2;
  logic [9:0]           nbits;
  logic [31:0]          seed;
  logic [255:0]         msg, msg2, word, exp_cur, snap;
  btfp_pkg::btfp_met_s  met;
  btfp_pkg::btfp_ice_s  ice;
  btfp_pkg::btfp_fast_s fast;
  btfp_pkg::btfp_slow_s slow, slow_cap;
  int                   error_cnt, checks, nseq, n2, gap, gap2;

  btfp_frame_packer #(.TICK_CYCLES(TC), .SEQ_MS(SM), .OFFSET_MS(OM)) dut (
    .btfp_unused_never_in_dummy_guard_in(1'b0), .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in), .second_pair_in(1'b0), .met_in(met), .ice_in(ice),
    .fast_in(fast), .slow_in(slow), .tx_start_in(tx_start), .msg_out(msg),
    .sequence_id_out(sequence_id), .msg_new_out(new1), .refresh_out(ref1),
    .slow_refresh_out(sref1), .tx_bit_out(tx_bit), .tx_bit_valid_out(tx_valid));
  btfp_frame_packer #(.TICK_CYCLES(TC), .SEQ_MS(SM), .OFFSET_MS(OM)) dut2 (
    .btfp_unused_never_in_dummy_guard_in(1'b0), .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in), .second_pair_in(1'b1), .met_in(met), .ice_in(ice),
    .fast_in(fast), .slow_in(slow), .tx_start_in(1'b0), .msg_out(msg2),
    .sequence_id_out(sid2), .msg_new_out(new2), .refresh_out(),
    .slow_refresh_out(), .tx_bit_out(), .tx_bit_valid_out());
  btfp_tx_model partner (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .req_in(req),
    .tx_bit_in(tx_bit), .tx_bit_valid_in(tx_valid), .tx_start_out(tx_start),
    .word_out(word), .sid_out(rsid), .bits_out(nbits), .done_out(done));

  // ********************
  // helpers
  // ********************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [255:0] expect_msg(input logic [2:0] s, btfp_pkg::btfp_met_s m,
      btfp_pkg::btfp_ice_s i, btfp_pkg::btfp_fast_s f, btfp_pkg::btfp_slow_s w);
    logic [29:0]  mid;
    logic [37:0]  head;
    logic [109:0] th;
    mid = (s == 3'h1) ? {m.mooring_tension[23:8], i.ice_battery_voltage, i.ice_day_number,
      i.ice_time_code} : (s == 3'h3) ? {m.mooring_tension[23:6], i.echo_depth}
      : {m.mooring_tension, f.transmitter_battery_voltage, f.logger_battery_voltage};
    th = (s == 3'h1) ? w.ice_thermistors[32:22] : (s == 3'h3) ? w.ice_thermistors[21:11]
      : w.ice_thermistors[10:0];
    head = (s == 3'h2) ? {1'b0, w.collector_condition, f.shallow_ctd_bytes, 1'b0}
      : (s == 3'h4) ? {w.water_filter_status, w.deep_ctd_bytes, 1'b0}
      : w.current_meter_bytes[37:0];
    // met fields are the top 71 bits of the met bundle, tension excluded
    if (s[0])
      return {s, m[94:24], mid, i.ice_stress, th};
    return {s, head, f.profiler_bytes[134:0], w.oxygen_ctd_bytes, f.light_attenuation,
      f.pigment_glow};
  endfunction
  task automatic cmp_word(input logic [255:0] got, input logic [255:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_num(input logic [31:0] got, input logic [31:0] exp);
    cmp_word({224'h0, got}, {224'h0, exp});
  endtask
  // first two sets are all ones and all zeros, then random
  task automatic drive(input int k);
    logic [827:0] r;
    for (int j = 0; j < 828; j++) begin
      r[j] = seed[0];
      seed = lfsr(seed);
    end
    if (k < 2)
      r = (k == 0) ? '1 : '0;
    {met, ice, fast, slow} = r;
  endtask
  task automatic final_report;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ********************
  // processes
  // ********************
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    error_cnt++;
    final_report;
  end
  // per-cycle monitor of both packers; inputs change only just after a new message
  initial begin
    want = 3'h1;
    want2 = 3'((OM / SM) % 6 + 1);
    forever begin
      @(posedge ref_clk_in);
      #1 gap++;
      gap2++;
      if (new1 === 1'b1) begin
        if (want == 3'h1)
          slow_cap = slow;
        exp_cur = expect_msg(want, met, ice, fast, slow_cap);
        cmp_word(msg, exp_cur);
        cmp_num(sequence_id, want);
        cmp_num({prev_ref, prev_sref}, {1'b1, want == 3'h1});
        if (nseq > 0)
          cmp_num(gap, PER);
        gap = 0;
        nseq++;
        want = (want == 3'h6) ? 3'h1 : want + 3'h1;
        drive(nseq);
      end
      if (new2 === 1'b1) begin
        cmp_num(sid2, want2);
        cmp_num(msg2[255:253], want2);
        if (n2 > 0)
          cmp_num(gap2, (n2 == 1) ? (SM - OM % SM) * TC : PER);
        gap2 = 0;
        n2++;
        want2 = (want2 == 3'h6) ? 3'h1 : want2 + 3'h1;
      end
      prev_ref = ref1;
      prev_sref = sref1;
    end
  end
  initial begin
    {error_cnt, checks, nseq, n2, gap, gap2} = '0;
    seed = 32'h624533c3;
    resetn_in = 1'b0;
    req = 1'b0;
    drive(0);
    repeat (10) @(posedge ref_clk_in);
    #1 resetn_in = 1'b1;
    wait (nseq == 2);
    @(posedge ref_clk_in);
    #1 snap = exp_cur;
    // request held during the burst must be ignored
    req = 1'b1;
    repeat (100) @(posedge ref_clk_in);
    #1 req = 1'b0;
    for (int w = 0; w < 600; w++) begin
      @(posedge ref_clk_in);
      #1 if (done === 1'b1) break;
    end
    cmp_word(word, snap);
    cmp_num(nbits, 32'h100);
    cmp_num(rsid, 3'h2);
    $display("test serial burst done");
    wait (nseq >= 14);
    $display("test sequence rotation done");
    #1 resetn_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1 cmp_word(msg, '0);
    cmp_num({sequence_id, new1, tx_valid}, 32'h0);
    $display("test mid-run reset done");
    final_report;
  end
endmodule
